/* File: nsel_pkg.sv */
// constants, types and register map of the sector ecc locator block
package nsel_pkg;

  localparam int ADDR_W       = 8;
  localparam int DATA_W       = 32;
  localparam int FIRST_SECTOR = 3;
  localparam int NUM_SECTORS  = 6;
  localparam int SECTOR_BYTES = 256;
  localparam int CNT_W        = 13;

  // byte addresses of the registers
  localparam logic [ADDR_W-1:0] OFF_SECTOR3 = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_SECTOR8 = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h1C;

  // locator field layout
  localparam int BIT_W      = 3;
  localparam int WORD_W     = 8;
  localparam int CODE_W     = BIT_W + WORD_W;
  localparam int BIT_LSB    = 0;
  localparam int WORD_LSB   = 3;
  localparam int INVPAR_LSB = 12;

  // status and control layout
  localparam int STAT_SINGLE_LSB = 0;
  localparam int STAT_MULTI_LSB  = 8;
  localparam int STAT_BUSY_BIT   = 16;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SIZE_LSB   = 1;
  localparam logic [2:0] CTRL_RESET = 3'h3;

  // page lengths in bytes
  localparam logic [CNT_W-1:0] PAGE_BYTES_512  = 13'h0200;
  localparam logic [CNT_W-1:0] PAGE_BYTES_2048 = 13'h0800;
  localparam logic [CNT_W-1:0] PAGE_BYTES_4096 = 13'h1000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PAGE_512  = 2'b00,
    PAGE_2048 = 2'b01,
    PAGE_4096 = 2'b10
  } nsel_page_size_t;

  typedef enum logic [1:0] {
    PG_IDLE  = 2'b00,
    PG_WRITE = 2'b01,
    PG_READ  = 2'b10
  } nsel_page_state_t;

  typedef struct packed {
    logic [CODE_W-1:0] inv_par;
    logic [WORD_W-1:0] word_index;
    logic [BIT_W-1:0]  bit_offset;
  } nsel_locator_t;

endpackage

/* File: nsel_sector_acc.sv */
// running position code and total parity over one 256-byte sector
`timescale 1ns/1ps
`default_nettype none
module nsel_sector_acc (
  input  wire logic                     clk_i,
  input  wire logic                     rstn_i,
  input  wire logic                     valid_i,
  input  wire logic                     first_i,
  input  wire logic [7:0]               data_i,
  input  wire logic [7:0]               word_i,
  output logic      [nsel_pkg::CODE_W-1:0] code_o,
  output logic                          parity_o
);
  logic                        odd;
  logic [2:0]                  bit_code;
  logic [nsel_pkg::CODE_W-1:0] contrib;
  logic [nsel_pkg::CODE_W-1:0] base_code;
  logic                        base_par;

  // xor of the positions of every set bit: word part only survives an odd count
  assign odd       = ^data_i;
  assign bit_code  = {data_i[4] ^ data_i[5] ^ data_i[6] ^ data_i[7],
                      data_i[2] ^ data_i[3] ^ data_i[6] ^ data_i[7],
                      data_i[1] ^ data_i[3] ^ data_i[5] ^ data_i[7]};
  assign contrib   = {(odd ? word_i : 8'h00), bit_code};
  assign base_code = first_i ? '0 : code_o;
  assign base_par  = first_i ? 1'b0 : parity_o;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      code_o   <= '0;
      parity_o <= 1'b0;
    end else if (valid_i) begin
      code_o   <= base_code ^ contrib;
      parity_o <= base_par ^ odd;
    end
  end
endmodule
`default_nettype wire

/* File: nsel_locator.sv */
// sector 3..8 ecc locator registers with an axi4-lite slave
// Contract
// - one code per 256-byte sector, pages of 512, 2048 or 4096 bytes of 8-bit words
// - sector 3 register covers page bytes 768 to 1023 only
// - sector 4 register covers page bytes 1024 to 1279 only
// - sector 5 register covers page bytes 1280 to 1535 only
// - sector 6 register covers page bytes 1536 to 1791 only
// - sector 7 register covers page bytes 1792 to 2047 only
// - sector 8 register covers page bytes 2048 to 2303 only
// - single error on read puts the flipped bit offset in the bit field
// - single error on read puts the faulty word address in the word field
// - with several errors the location fields are meaningless
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module nsel_locator (
  input  wire logic                          CLK_I,
  input  wire logic                          RSTN_I,
  input  wire logic                          PAGE_START_I,
  input  wire logic                          PAGE_WRITE_I,
  input  wire logic                          DATA_VALID_I,
  input  wire logic [7:0]                    DATA_I,
  input  wire logic [nsel_pkg::ADDR_W-1:0]   AWADDR,
  input  wire logic                          AWVALID,
  output logic                               AWREADY,
  input  wire logic [nsel_pkg::DATA_W-1:0]   WDATA,
  input  wire logic [3:0]                    WSTRB,
  input  wire logic                          WVALID,
  output logic                               WREADY,
  output logic [1:0]                         BRESP,
  output logic                               BVALID,
  input  wire logic                          BREADY,
  input  wire logic [nsel_pkg::ADDR_W-1:0]   ARADDR,
  input  wire logic                          ARVALID,
  output logic                               ARREADY,
  output logic [nsel_pkg::DATA_W-1:0]        RDATA,
  output logic [1:0]                         RRESP,
  output logic                               RVALID,
  input  wire logic                          RREADY
);
  localparam int NS = nsel_pkg::NUM_SECTORS;

  nsel_pkg::nsel_page_state_t      state;
  nsel_pkg::nsel_page_state_t      next_state;
  logic [nsel_pkg::CNT_W-1:0]      cnt;
  logic [2:0]                      control;
  logic [1:0]                      page_size;
  logic [nsel_pkg::CNT_W-1:0]      page_bytes;
  logic                            in_page;
  logic                            byte_take;
  logic                            sector_first;
  logic                            sector_last;
  logic                            page_last;
  logic                            commit;
  logic                            commit_write;
  logic [3:0]                      commit_sec;
  logic [nsel_pkg::CODE_W-1:0]     acc_code;
  logic                            acc_par;
  logic [nsel_pkg::DATA_W-1:0]     sector_word [NS];
  logic [NS-1:0]                   single_flags;
  logic [NS-1:0]                   multi_flags;
  logic [nsel_pkg::DATA_W-1:0]     status_word;
  logic [nsel_pkg::DATA_W-1:0]     control_word;

  // page data path: byte counter and page state
  assign page_bytes   = (page_size == nsel_pkg::PAGE_512)  ? nsel_pkg::PAGE_BYTES_512  :
                        (page_size == nsel_pkg::PAGE_2048) ? nsel_pkg::PAGE_BYTES_2048 :
                                                             nsel_pkg::PAGE_BYTES_4096;
  assign in_page      = (cnt < page_bytes);
  assign byte_take    = DATA_VALID_I && (state != nsel_pkg::PG_IDLE) && in_page && !PAGE_START_I;
  assign sector_first = byte_take && (cnt[7:0] == 8'h00);
  assign sector_last  = byte_take && (cnt[7:0] == 8'hFF);
  assign page_last    = byte_take && (cnt == page_bytes - 13'h0001);

  always_comb begin
    next_state = state;
    if (PAGE_START_I && control[nsel_pkg::CTRL_ENABLE_BIT]) begin
      next_state = PAGE_WRITE_I ? nsel_pkg::PG_WRITE : nsel_pkg::PG_READ;
    end else if (PAGE_START_I || page_last) begin
      next_state = nsel_pkg::PG_IDLE;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state     <= nsel_pkg::PG_IDLE;
      cnt       <= '0;
      page_size <= nsel_pkg::PAGE_2048;
    end else begin
      state <= next_state;
      if (PAGE_START_I) begin
        cnt       <= '0;
        page_size <= control[nsel_pkg::CTRL_SIZE_LSB +: 2];
      end else if (byte_take) begin
        cnt <= cnt + 13'h0001;
      end
    end
  end

  // commit one cycle after a sector's last byte, once the accumulator holds it
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      commit       <= 1'b0;
      commit_write <= 1'b0;
      commit_sec   <= 4'h0;
    end else begin
      commit       <= sector_last;
      commit_write <= (state == nsel_pkg::PG_WRITE);
      commit_sec   <= cnt[11:8];
    end
  end

  nsel_sector_acc u_acc (
    .clk_i    (CLK_I),
    .rstn_i   (RSTN_I),
    .valid_i  (byte_take),
    .first_i  (sector_first),
    .data_i   (DATA_I),
    .word_i   (cnt[7:0]),
    .code_o   (acc_code),
    .parity_o (acc_par)
  );

  // one locator per sector; a write page stores the inverted code, a read page
  // compares against it. stored code lives only here, hence the spare-area copy
  for (genvar i = 0; i < NS; i++) begin : gen_sec
    nsel_pkg::nsel_locator_t     loc;
    logic                        ref_par;
    logic                        single;
    logic                        multi;
    logic                        sel;
    logic [nsel_pkg::CODE_W-1:0] syn;
    logic                        mism;

    // sector i+3 owns page bytes 256*(i+3) .. 256*(i+3)+255
    assign sel  = commit && (commit_sec == 4'(nsel_pkg::FIRST_SECTOR + i));
    assign syn  = acc_code ^ ~loc.inv_par;
    assign mism = acc_par ^ ref_par;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
        loc     <= '0;
        ref_par <= 1'b0;
        single  <= 1'b0;
        multi   <= 1'b0;
      end else if (sel && commit_write) begin
        loc.inv_par    <= ~acc_code;
        loc.word_index <= 8'h00;
        loc.bit_offset <= 3'h0;
        ref_par        <= acc_par;
        single         <= 1'b0;
        multi          <= 1'b0;
      end else if (sel) begin
        single <= mism;
        multi  <= !mism && (syn != '0);
        if (mism || (syn != '0)) begin
          loc.word_index <= syn[nsel_pkg::CODE_W-1:nsel_pkg::BIT_W];
          loc.bit_offset <= syn[nsel_pkg::BIT_W-1:0];
        end
      end
    end

    // field layout: 3-bit offset, 8-bit word, gap bit, 11-bit inverse code
    assign sector_word[i] = {9'h000, loc.inv_par, 1'b0, loc.word_index, loc.bit_offset};
    assign single_flags[i] = single;
    assign multi_flags[i]  = multi;
  end

  assign status_word  = {15'h0000, (state != nsel_pkg::PG_IDLE), 2'h0, multi_flags, 2'h0, single_flags};
  assign control_word = {29'h00000000, control};

  // axi4-lite slave: one write and one read in flight
  logic                        aw_held;
  logic                        w_held;
  logic [nsel_pkg::ADDR_W-1:0] aw_addr;
  logic [nsel_pkg::DATA_W-1:0] w_data;
  logic                        w_lane0;
  logic                        do_write;
  logic                        wr_is_ctrl;
  logic                        rd_mapped;
  logic [2:0]                  rd_idx;
  logic [nsel_pkg::DATA_W-1:0] rd_word;

  assign do_write   = aw_held && w_held && !BVALID;
  // only control is writable; locators are read-only
  assign wr_is_ctrl = (aw_addr == nsel_pkg::OFF_CONTROL);
  assign rd_mapped  = (ARADDR[1:0] == 2'h0) && (ARADDR <= nsel_pkg::OFF_CONTROL);
  assign rd_idx     = ARADDR[4:2];
  assign rd_word    = (rd_idx < 3'(NS))  ? sector_word[rd_idx] :
                      (rd_idx == 3'h6)   ? status_word : control_word;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      AWREADY <= 1'b1;
      WREADY  <= 1'b1;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_lane0 <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= nsel_pkg::RESP_OKAY;
      control <= nsel_pkg::CTRL_RESET;
    end else begin
      if (AWVALID && AWREADY) begin
        AWREADY <= 1'b0;
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        WREADY  <= 1'b0;
        w_held  <= 1'b1;
        w_data  <= WDATA;
        w_lane0 <= WSTRB[0];
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        BVALID  <= 1'b1;
        BRESP   <= wr_is_ctrl ? nsel_pkg::RESP_OKAY : nsel_pkg::RESP_SLVERR;
        if (wr_is_ctrl && w_lane0) begin
          control <= w_data[2:0];
        end
      end
      if (BVALID && BREADY) begin
        BVALID  <= 1'b0;
        AWREADY <= 1'b1;
        WREADY  <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ARREADY <= 1'b1;
      RVALID  <= 1'b0;
      RDATA   <= '0;
      RRESP   <= nsel_pkg::RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b1;
      RDATA   <= rd_mapped ? rd_word : 32'h00000000;
      RRESP   <= rd_mapped ? nsel_pkg::RESP_OKAY : nsel_pkg::RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      RVALID  <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  commit_after_last_a: assert property (sector_last |=> commit && commit_sec == $past(cnt[11:8]))
    else $error("commit did not follow the last byte of a sector");

  commit_spacing_a: assert property (commit |=> !commit)
    else $error("two commits in consecutive cycles");

  sector3_single_a: assert property (
    gen_sec[0].sel && !commit_write && gen_sec[0].mism
    |=> gen_sec[0].single && {sector_word[0][10:3], sector_word[0][2:0]} == $past(gen_sec[0].syn))
    else $error("sector 3 single error not reported at its location");

  sector8_bytes_a: assert property (
    gen_sec[5].sel |-> $past(cnt, 1) == 13'h08FF || $past(PAGE_START_I, 1))
    else $error("sector 8 committed outside bytes 2048 to 2303");

  bit_offset_a: assert property (
    commit && !commit_write && commit_sec == 4'h4 && gen_sec[1].mism
    |=> sector_word[1][2:0] == ($past(acc_code[2:0]) ^ ~$past(gen_sec[1].loc.inv_par[2:0])))
    else $error("sector 4 bit offset wrong after single error");

  word_index_a: assert property (
    commit && !commit_write && commit_sec == 4'h6 && gen_sec[3].mism
    |=> sector_word[3][10:3] == $past(gen_sec[3].syn[10:3]))
    else $error("sector 6 word index wrong after single error");

  multi_flag_a: assert property (
    gen_sec[2].sel && !commit_write && !gen_sec[2].mism && gen_sec[2].syn != '0
    |=> gen_sec[2].multi && !gen_sec[2].single)
    else $error("sector 5 multiple error not flagged");

  write_store_a: assert property (
    gen_sec[3].sel && commit_write |=> sector_word[3][22:12] == ~$past(acc_code) && sector_word[3][10:0] == 11'h000)
    else $error("sector 6 write page did not store the inverse code");

  ro_write_a: assert property (
    do_write && !wr_is_ctrl |=> BVALID && BRESP == nsel_pkg::RESP_SLVERR && $stable(control))
    else $error("write to a read-only register was not refused");

  reserved_zero_a: assert property (RVALID |-> RDATA[31:23] == 9'h000)
    else $error("reserved high bits read as non-zero");

  read_answer_a: assert property (ARVALID && ARREADY |=> RVALID [*1] ##0 !ARREADY)
    else $error("read answer not one cycle after address");

  // bus answers stand until the master takes them
  write_answer_a: assert property (do_write |=> BVALID && !AWREADY && !WREADY)
    else $error("write response not raised after address and data");

  bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped before it was taken");

  rdata_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
    else $error("read data changed before it was taken");

  bad_read_a: assert property (
    ARVALID && ARREADY && ARADDR[1:0] != 2'h0
    |=> RVALID && RRESP == nsel_pkg::RESP_SLVERR && RDATA == 32'h00000000)
    else $error("unaligned read not refused");

  // page length and sector ownership
  page_end_a: assert property (page_last |=> state == nsel_pkg::PG_IDLE)
    else $error("page did not end after its last byte");

  small_page_a: assert property (
    commit && page_size == nsel_pkg::PAGE_512 |-> commit_sec <= 4'h1)
    else $error("short page reached a sector beyond its length");

  write_clear_a: assert property (
    gen_sec[0].sel && commit_write |=> sector_word[0][10:0] == 11'h000 && !gen_sec[0].multi)
    else $error("sector 3 write page left a stale location");

  sector4_keep_a: assert property (
    commit && !commit_write && commit_sec == 4'h4 && !gen_sec[1].mism && gen_sec[1].syn == '0
    |=> $stable(sector_word[1][10:0]) && !gen_sec[1].single && !gen_sec[1].multi)
    else $error("sector 4 location changed on a clean read");

  sector5_single_a: assert property (
    gen_sec[2].sel && !commit_write && gen_sec[2].mism
    |=> gen_sec[2].single && sector_word[2][10:0] == $past(gen_sec[2].syn))
    else $error("sector 5 single error not reported at its location");

  sector7_stable_a: assert property (!gen_sec[4].sel |=> $stable(sector_word[4]))
    else $error("sector 7 register changed outside its commit");

  sector8_store_a: assert property (
    gen_sec[5].sel && commit_write |=> sector_word[5][22:12] == ~$past(acc_code) && !gen_sec[5].single)
    else $error("sector 8 write page did not store the inverse code");

  single_seen_c: cover property (commit && !commit_write && |single_flags);
  multi_seen_c:  cover property (|multi_flags);
  page_write_c:  cover property (gen_sec[5].sel && commit_write);
  ctrl_write_c:  cover property (do_write && wr_is_ctrl ##1 BVALID && BREADY);
  small_page_c:  cover property (PAGE_START_I && control[nsel_pkg::CTRL_SIZE_LSB +: 2] == 2'h0);
endmodule
`default_nettype wire

/* File: nsel_page_src.sv */
// page byte source standing in for the flash data path
`timescale 1ns/1ps
`default_nettype none
module nsel_page_src (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        go_i,
  input  wire logic        wr_i,
  input  wire logic [12:0] len_i,
  input  wire logic [12:0] flip_a_i,
  input  wire logic [12:0] flip_b_i,
  input  wire logic [2:0]  flip_bit_i,
  output logic             start_o,
  output logic             write_o,
  output logic             valid_o,
  output logic [7:0]       data_o,
  output logic             done_o
);
  logic        active;
  logic        stall;
  logic [12:0] idx;
  wire  [7:0]  mask = 8'h01 << flip_bit_i;
  wire  [7:0]  flip = ((idx == flip_a_i) ? mask : 8'h00) ^ ((idx == flip_b_i) ? mask : 8'h00);
  assign done_o = !active;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      active  <= 1'b0;
      stall   <= 1'b0;
      idx     <= 13'h0000;
      start_o <= 1'b0;
      write_o <= 1'b0;
      valid_o <= 1'b0;
      data_o  <= 8'h00;
    end else begin
      start_o <= go_i;
      valid_o <= 1'b0;
      // released line toggles so a stale byte is never mistaken for data
      data_o  <= ~data_o;
      if (go_i) begin
        write_o <= wr_i;
        idx     <= 13'h0000;
        stall   <= 1'b0;
        active  <= 1'b1;
      end else if (active) begin
        if (idx == len_i) begin
          active <= 1'b0;
        end else if (idx[3:0] == 4'hF && !stall) begin
          stall <= 1'b1; // slow source: one idle cycle every 16 bytes
        end else begin
          stall   <= 1'b0;
          valid_o <= 1'b1;
          data_o  <= idx[7:0] ^ {idx[11:8], idx[11:8]} ^ flip;
          idx     <= idx + 13'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the sector locator registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [12:0] NONE = 13'h1FFF;
  logic        CLK_I, RSTN_I, PAGE_START_I, PAGE_WRITE_I, DATA_VALID_I;
  logic [7:0]  DATA_I, AWADDR, ARADDR;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
  logic [31:0] WDATA, RDATA, r;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP;
  logic        go, pwr, pdone;
  logic [12:0] plen, fa, fb;
  logic [2:0]  fbit;
  logic [65:0] rq[$];
  logic [1:0]  bq[$];
  int          failures, checked;

  nsel_locator uut (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .PAGE_START_I(PAGE_START_I), .PAGE_WRITE_I(PAGE_WRITE_I),
    .DATA_VALID_I(DATA_VALID_I), .DATA_I(DATA_I), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY));
  nsel_page_src src (.clk_i(CLK_I), .rstn_i(RSTN_I), .go_i(go), .wr_i(pwr), .len_i(plen), .flip_a_i(fa),
    .flip_b_i(fb), .flip_bit_i(fbit), .start_o(PAGE_START_I), .write_o(PAGE_WRITE_I), .valid_o(DATA_VALID_I),
    .data_o(DATA_I), .done_o(pdone));

  always #5 CLK_I = ~CLK_I;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_r(input logic [31:0] got, input logic [1:0] gr, input logic [65:0] n);
    checked++;
    if (((got & n[33:2]) !== n[65:34]) || (gr !== n[1:0])) begin
      failures++;
      $display("mismatch at %0t: read data %h resp %h", $time, got, gr);
    end
  endtask

  task automatic cmp_b(input logic [1:0] got, input logic [1:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: write resp %h", $time, got);
    end
  endtask

  // results are matched in order against the notes left by the bus tasks
  always @(posedge CLK_I) begin
    if (RVALID === 1'b1 && RREADY === 1'b1 && rq.size() > 0) cmp_r(RDATA, RRESP, rq.pop_front());
    if (BVALID === 1'b1 && BREADY === 1'b1 && bq.size() > 0) cmp_b(BRESP, bq.pop_front());
  end

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] rs);
    rq.push_back({e, m, rs});
    @(posedge CLK_I);
    ARADDR  <= a;
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    do @(posedge CLK_I); while (ARREADY !== 1'b1);
    ARVALID <= 1'b0;
    while (RVALID !== 1'b1) @(posedge CLK_I);
    RREADY <= 1'b0;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] rs);
    logic aw, w;
    aw = 1'b0;
    w  = 1'b0;
    bq.push_back(rs);
    @(posedge CLK_I);
    AWADDR  <= a;
    AWVALID <= 1'b1;
    WDATA   <= d;
    WSTRB   <= st;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge CLK_I);
      if (AWVALID && AWREADY === 1'b1) begin
        aw = 1'b1;
        AWVALID <= 1'b0;
      end
      if (WVALID && WREADY === 1'b1) begin
        w = 1'b1;
        WVALID <= 1'b0;
      end
    end
    do @(posedge CLK_I); while (BVALID !== 1'b1);
    BREADY <= 1'b0;
  endtask

  task automatic run_page(input logic wr, input logic [12:0] len, a, b, input logic [2:0] bt);
    @(posedge CLK_I);
    go   <= 1'b1;
    pwr  <= wr;
    plen <= len;
    fa   <= a;
    fb   <= b;
    fbit <= bt;
    @(posedge CLK_I);
    go <= 1'b0;
    do @(posedge CLK_I); while (pdone !== 1'b1);
    repeat (3) @(posedge CLK_I); // commit lands two edges after the last byte
  endtask

  task automatic check_read(input logic [12:0] a, input logic [2:0] bt, input logic [12:0] b, len);
    logic [4:0]  sec;
    logic [31:0] e;
    sec = a[12:8];
    e   = 32'h0;
    run_page(1'b0, len, a, b, bt);
    if (a < len && sec >= 5'h03 && sec <= 5'h08) begin
      if (b == NONE) e[sec - 5'h03] = 1'b1;
      else e[sec + 5'h05] = 1'b1;
    end
    axi_rd(nsel_pkg::OFF_STATUS, e, (len == 13'h0800) ? 32'h11F1F : 32'h13F3F, nsel_pkg::RESP_OKAY);
    if (e[5:0] != 6'h00) axi_rd(8'({sec - 5'h03, 2'b00}), 32'({a[7:0], bt}), 32'h7FF, nsel_pkg::RESP_OKAY);
  endtask

  initial begin
    // the full run needs roughly 57k cycles
    repeat (80000) @(posedge CLK_I);
    failures++;
    test_done();
  end

  initial begin
    {CLK_I, RSTN_I, go, pwr, AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
    {AWADDR, ARADDR, WDATA, WSTRB, fa, fb, fbit} = '0;
    plen = 13'h1000;
    r    = 32'h3f0d;
    repeat (2) @(posedge CLK_I);
    RSTN_I <= 1'b1;
    for (int i = 0; i < 6; i++) axi_rd(8'(i * 4), 32'h0, 32'hFFFFFFFF, nsel_pkg::RESP_OKAY);
    axi_rd(nsel_pkg::OFF_CONTROL, 32'h3, 32'hFFFFFFFF, nsel_pkg::RESP_OKAY);
    axi_wr(nsel_pkg::OFF_SECTOR3, 32'hFFFFFFFF, 4'hF, nsel_pkg::RESP_SLVERR);
    axi_rd(nsel_pkg::OFF_SECTOR3, 32'h0, 32'hFFFFFFFF, nsel_pkg::RESP_OKAY);
    axi_rd(8'h20, 32'h0, 32'hFFFFFFFF, nsel_pkg::RESP_SLVERR);
    axi_rd(8'h02, 32'h0, 32'hFFFFFFFF, nsel_pkg::RESP_SLVERR);
    axi_wr(nsel_pkg::OFF_CONTROL, 32'h5, 4'hE, nsel_pkg::RESP_OKAY);
    axi_rd(nsel_pkg::OFF_CONTROL, 32'h3, 32'h7, nsel_pkg::RESP_OKAY);
    axi_wr(nsel_pkg::OFF_CONTROL, 32'h5, 4'hF, nsel_pkg::RESP_OKAY);
    run_page(1'b1, 13'h1000, NONE, NONE, 3'h0);
    // host copies every locator for the spare area; reserved bits must read zero
    for (int i = 0; i < 6; i++) axi_rd(8'(i * 4), 32'h0, 32'hFF800FFF, nsel_pkg::RESP_OKAY);
    for (int s = 3; s <= 8; s++) begin
      r = lfsr(r);
      check_read({5'(s), (s == 3) ? 8'h00 : (s == 8) ? 8'hFF : r[7:0]}, r[10:8], NONE, 13'h1000);
    end
    check_read(13'h02FF, 3'h6, NONE, 13'h1000);
    check_read(13'h0900, 3'h1, NONE, 13'h1000);
    check_read(13'h0406, 3'h2, 13'h0464, 13'h1000);
    axi_wr(nsel_pkg::OFF_CONTROL, 32'h3, 4'hF, nsel_pkg::RESP_OKAY);
    check_read(13'h07FF, 3'h4, NONE, 13'h0800);
    check_read(13'h0834, 3'h3, NONE, 13'h0800);
    // short page: the flipped byte lies beyond 512, so sector 3 must stay clean
    axi_wr(nsel_pkg::OFF_CONTROL, 32'h1, 4'hF, nsel_pkg::RESP_OKAY);
    run_page(1'b0, 13'h1000, 13'h0310, NONE, 3'h5);
    axi_rd(nsel_pkg::OFF_STATUS, 32'h0, 32'h13F3F, nsel_pkg::RESP_OKAY);
    // disabled unit: a full page with an error must leave every flag alone
    axi_wr(nsel_pkg::OFF_CONTROL, 32'h4, 4'hF, nsel_pkg::RESP_OKAY);
    run_page(1'b0, 13'h1000, 13'h0310, NONE, 3'h5);
    axi_rd(nsel_pkg::OFF_STATUS, 32'h0, 32'h13F3F, nsel_pkg::RESP_OKAY);
    axi_rd(nsel_pkg::OFF_CONTROL, 32'h4, 32'hFFFFFFFF, nsel_pkg::RESP_OKAY);
    test_done();
  end
endmodule
`default_nettype wire
